// *** shared/sram_port_pkg.sv ***
// constants and types shared by the sync sram port design
package sram_port_pkg;
    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int ADDR_W      = 19;       // 512K locations
    localparam int LANES       = 4;        // byte lanes
    localparam int LANE_W      = 9;        // eight data bits plus parity
    localparam int DATA_W      = LANES * LANE_W;
    localparam int BURST_W     = 2;        // two-bit burst counter
    localparam int BURST_LSB   = 0;        // position of the low bits
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0]  RST_ADDR  = 19'h00000;
    localparam logic [BURST_W-1:0] RST_BURST = 2'h0;
    localparam logic [DATA_W-1:0]  RST_DATA  = 36'h000000000;
    localparam logic               RST_FLAG  = 1'b0;
    localparam logic               RST_OE_N  = 1'b1;
    localparam logic               RST_LONG  = 1'b1;  // third select fitted
    // ------------------------------------------------------------
    // cycle kinds decoded from the sampled controls
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        cyc_idle,
        cyc_read,
        cyc_write
    } cycle_kind_t;
endpackage

// *** shared/sram_ctl_if.sv ***
// interface carrying sampled controls into the burst address unit
`timescale 1ns/100ps
`default_nettype none
interface sram_ctl_if;
    import sram_port_pkg::*;
    logic                load;      // capture a new start address
    logic                advance;   // step the burst counter
    logic [ADDR_W-1:0]   addr_in;   // address presented with the strobe
    logic [ADDR_W-1:0]   addr_out;  // current burst address
    modport ctl (output load, output advance, output addr_in,
                 input addr_out);
    modport unit (input load, input advance, input addr_in,
                  output addr_out);
endinterface
`default_nettype wire

// *** hw/burst_addr_unit.sv ***
// start address register and two-bit burst counter
`timescale 1ns/100ps
`default_nettype none
module burst_addr_unit
    import sram_port_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   rst_n,
    sram_ctl_if.unit    ctl
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0]  base;   // captured upper address
        logic [BURST_W-1:0] count;  // burst position
    } burst_state_t;

    burst_state_t state;       // registered state
    burst_state_t next_state;  // next value

    // load wins over advance, advance steps, otherwise hold
    always_comb begin
        next_state = state;
        if (ctl.load) begin
            next_state.base  = ctl.addr_in;
            next_state.count = ctl.addr_in[BURST_LSB +: BURST_W];
        end else if (ctl.advance) begin
            next_state.count = state.count + 2'h1;
        end
    end

    // register the state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '{base: RST_ADDR, count: RST_BURST};
        end else begin
            state <= next_state;
        end
    end

    // low bits replaced by the counter
    assign ctl.addr_out = {state.base[ADDR_W-1:BURST_W], state.count};
endmodule
`default_nettype wire

// *** hw/sync_sram_port.sv ***
// pipelined double-cycle-deselect sync sram control port
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - latch address on strobe while fully selected
// - load low address bits into counter
// - lane select writes only with qualifier low
// - global write writes every lane
// - advance low steps counter, else hold
// - processor strobe ignored when first select high
// - selected: first low, second high, third low
// - missing third select counts as asserted
// - output enable low drives, high floats
// - first read after deselect keeps lines undriven
// - processor strobe captures address, loads counter
// - both strobes: processor strobe wins
// - controller strobe captures address, loads counter
// - read data two cycles after the sampled address
module sync_sram_port
    import sram_port_pkg::*;
#(
    parameter int DEPTH = 16  // words backed in this model of the array
)(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              processor_addr_strobe_n,
    input  wire logic              controller_addr_strobe_n,
    input  wire logic              burst_advance_n,
    input  wire logic              lane_write_qualify_n,
    input  wire logic              all_lanes_write_n,
    input  wire logic [LANES-1:0]  lane_write_select_n,
    input  wire logic              chip_select_first_n,
    input  wire logic              chip_select_second,
    input  wire logic              chip_select_third_n,
    input  wire logic              third_select_fitted,
    input  wire logic              output_enable_n,
    input  wire logic [DATA_W-1:0] data_in,
    output logic      [DATA_W-1:0] data_out,
    output logic                   data_oe
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int SYNC_W = ADDR_W + 9 + LANES + DATA_W;
    logic [SYNC_W-1:0] pins_raw;   // raw pin bundle
    logic [SYNC_W-1:0] sync_a;     // first stage, read only by sync_b
    logic [SYNC_W-1:0] sync_b;     // second stage
    logic              oe_a;       // output enable first stage
    logic              oe_b;       // output enable second stage

    assign pins_raw = {addr, processor_addr_strobe_n,
                       controller_addr_strobe_n, burst_advance_n,
                       lane_write_qualify_n, all_lanes_write_n,
                       chip_select_first_n, chip_select_second,
                       chip_select_third_n, third_select_fitted,
                       lane_write_select_n, data_in};

    // two flops on every pin; at reset idle pins read as inactive except first select, which reads low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_a <= {{ADDR_W{1'b0}}, 5'h1f, 4'h2, {LANES{1'b1}},
                       {DATA_W{1'b0}}};
            sync_b <= {{ADDR_W{1'b0}}, 5'h1f, 4'h2, {LANES{1'b1}},
                       {DATA_W{1'b0}}};
            oe_a   <= RST_OE_N;
            oe_b   <= RST_OE_N;
        end else begin
            sync_a <= pins_raw;
            sync_b <= sync_a;
            oe_a   <= output_enable_n;
            oe_b   <= oe_a;
        end
    end

    // ------------------------------------------------------------
    // unpack synchronised pins
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] s_addr;     // sampled address
    logic              s_pstrobe_n; // processor strobe
    logic              s_cstrobe_n; // controller strobe
    logic              s_step_n;    // burst advance
    logic              s_qual_n;   // lane write qualifier
    logic              s_all_n;    // global write
    logic              s_cs1_n;    // first select
    logic              s_cs2;      // second select
    logic              s_cs3_n;    // third select
    logic              s_fitted;   // third select present
    logic [LANES-1:0]  s_lane_n;   // lane selects
    logic [DATA_W-1:0] s_data;     // write data

    assign {s_addr, s_pstrobe_n, s_cstrobe_n, s_step_n, s_qual_n, s_all_n,
            s_cs1_n, s_cs2, s_cs3_n, s_fitted, s_lane_n, s_data} = sync_b;

    // ------------------------------------------------------------
    // select and strobe decode
    // ------------------------------------------------------------
    logic             cs3_active;  // third select, forced when absent
    logic             selected;    // all selects active
    logic             pstrobe_take; // processor strobe recognised
    logic             cstrobe_take; // controller strobe recognised
    logic             burst_active; // inside a selected burst
    logic             strobe;      // a new address is taken
    logic [LANES-1:0] lane_we;     // per-lane write this cycle
    cycle_kind_t      kind;        // decoded cycle

    assign cs3_active = !s_fitted || !s_cs3_n;
    assign selected   = !s_cs1_n && s_cs2 && cs3_active;
    assign pstrobe_take = !s_pstrobe_n && !s_cs1_n;
    assign cstrobe_take = !s_cstrobe_n && !pstrobe_take;
    assign strobe       = (pstrobe_take || cstrobe_take) && selected;

    // lane write enables
    generate
        for (genvar i = 0; i < LANES; i++) begin : g_lane
            assign lane_we[i] = !s_all_n || (!s_qual_n && !s_lane_n[i]);
        end
    endgenerate

    // ------------------------------------------------------------
    // burst address unit
    // ------------------------------------------------------------
    sram_ctl_if ctl_bus ();

    assign ctl_bus.load    = strobe;
    assign ctl_bus.addr_in = s_addr;
    assign ctl_bus.advance = !strobe && !s_step_n && burst_active;

    burst_addr_unit u_burst (
        .clk   (clk),
        .rst_n (rst_n),
        .ctl   (ctl_bus.unit)
    );

    // ------------------------------------------------------------
    // port state
    // ------------------------------------------------------------
    typedef struct packed {
        logic              active;    // burst running
        logic              rd_pend;   // read issued last cycle
        logic              rd_valid;  // read data held in output stage
        logic              rd_fresh;  // read issued right after deselect
        logic              first_rd;  // first output cycle to mask
        logic              dcd;       // extra deselect stage
        logic [DATA_W-1:0] rdata;     // output register
    } port_state_t;

    port_state_t state;       // registered state
    port_state_t next_state;  // next value

    logic [DATA_W-1:0] mem [DEPTH];  // backing array
    logic [$clog2(DEPTH)-1:0] widx;  // array index of current address

    assign burst_active = state.active;
    assign widx = ctl_bus.addr_out[$clog2(DEPTH)-1:0];

    // kind of the cycle now presented
    always_comb begin
        kind = cyc_idle;
        if (strobe || state.active) begin
            if (lane_we != '0) begin
                kind = cyc_write;
            end else begin
                kind = cyc_read;
            end
        end
    end

    // next port state
    always_comb begin
        next_state          = state;
        next_state.rd_pend  = 1'b0;
        if (strobe) begin
            next_state.active = 1'b1;
        end else if (pstrobe_take || cstrobe_take) begin
            // recognised strobe while deselected ends the burst
            next_state.active = 1'b0;
        end
        next_state.rd_pend  = (kind == cyc_read);
        next_state.rd_valid = state.rd_pend;
        if (state.rd_pend) begin
            next_state.rdata = mem[widx];
        end
        // mask first output cycle after deselect
        next_state.rd_fresh = (kind == cyc_read) && !state.dcd;
        next_state.first_rd = state.rd_fresh;
        next_state.dcd      = (kind != cyc_idle);
    end

    // register the state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '{active: RST_FLAG, rd_pend: RST_FLAG,
                       rd_valid: RST_FLAG, rd_fresh: RST_FLAG,
                       first_rd: RST_FLAG,
                       dcd: RST_FLAG, rdata: RST_DATA};
        end else begin
            state <= next_state;
        end
    end

    // array write, lane by lane
    always_ff @(posedge clk) begin
        if (kind == cyc_write) begin
            for (int i = 0; i < LANES; i++) begin
                if (lane_we[i]) begin
                    mem[widx][i*LANE_W +: LANE_W] <=
                        s_data[i*LANE_W +: LANE_W];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // output drive
    // ------------------------------------------------------------
    assign data_out = state.rdata;
    assign data_oe  = !oe_b && state.rd_valid && !state.first_rd;
endmodule
`default_nettype wire

// *** verif/sync_sram_port_chk.sv ***
// pin-level assertions for the sync sram port
`timescale 1ns/100ps
`default_nettype none
module sync_sram_port_chk
    import sram_port_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              processor_addr_strobe_n,
    input wire logic              controller_addr_strobe_n,
    input wire logic              burst_advance_n,
    input wire logic              lane_write_qualify_n,
    input wire logic              all_lanes_write_n,
    input wire logic              chip_select_first_n,
    input wire logic              chip_select_second,
    input wire logic              chip_select_third_n,
    input wire logic              third_select_fitted,
    input wire logic              output_enable_n,
    input wire logic [DATA_W-1:0] data_out,
    input wire logic              data_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic no_wr; // no write of any kind
    logic desel; // controller strobe with a select inactive
    logic rd_on; // processor read, fully selected, enable low
    assign no_wr = all_lanes_write_n && lane_write_qualify_n;
    assign desel = !controller_addr_strobe_n && (chip_select_first_n
        || !chip_select_second || (chip_select_third_n && third_select_fitted));
    assign rd_on = !processor_addr_strobe_n && !chip_select_first_n
        && chip_select_second && no_wr && !output_enable_n
        && !(chip_select_third_n && third_select_fitted);
    reset_quiet_a: assert property ($rose(rst_n) |->
        !data_oe && data_out == '0) else $error("lines live after reset");
    oe_float_a: assert property (output_enable_n [*4] |-> !data_oe)
        else $error("drives with enable high");
    oe_cause_a: assert property ($rose(data_oe) |->
        !$past(output_enable_n, 2) || !$past(output_enable_n, 3))
        else $error("drive began without enable");
    first_off_a: assert property ((desel && chip_select_first_n) [*8]
        |-> !data_oe) else $error("drives while deselected");
    second_off_a: assert property ((desel && !chip_select_second) [*8]
        |-> !data_oe) else $error("drives while deselected");
    third_off_a: assert property ((desel && chip_select_third_n) [*8]
        |-> !data_oe) else $error("drives while deselected");
    read_mask_a: assert property (desel [*6] ##1 rd_on |-> ##4 !data_oe)
        else $error("first read after deselect drove");
    idle_hold_a: assert property ((controller_addr_strobe_n
        && burst_advance_n && no_wr
        && (processor_addr_strobe_n || chip_select_first_n)) [*7]
        |-> $stable(data_out)) else $error("read data moved while idle");
    cover property (rd_on ##4 data_oe);
    cover property (desel [*6] ##1 rd_on);
    cover property ($rose(data_oe));
endmodule
bind sync_sram_port sync_sram_port_chk chk (.*);
`default_nettype wire

// *** verif/sram_host_model.sv ***
// bus master model driving the sync sram port pins
`timescale 1ns/100ps
`default_nettype none
module sram_host_model
    import sram_port_pkg::*;
(
    input  wire logic              clk,
    input  wire logic [DATA_W-1:0] data_out,
    input  wire logic              data_oe,
    output logic      [ADDR_W-1:0] addr,
    output logic                   processor_addr_strobe_n,
    output logic                   controller_addr_strobe_n,
    output logic                   burst_advance_n,
    output logic                   lane_write_qualify_n,
    output logic                   all_lanes_write_n,
    output logic      [LANES-1:0]  lane_write_select_n,
    output logic                   chip_select_first_n,
    output logic                   chip_select_second,
    output logic                   chip_select_third_n,
    output logic                   third_select_fitted,
    output logic                   output_enable_n,
    output logic      [DATA_W-1:0] data_in
);
    logic [DATA_W-1:0] host_d; // host level on the shared lines
    // shared lines: the port wins while it drives
    assign data_in = data_oe ? data_out : host_d;
    initial begin
        addr = '0;
        {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n,
         all_lanes_write_n, lane_write_qualify_n} = 5'h1f;
        lane_write_select_n = '1;
        {output_enable_n, chip_select_first_n, chip_select_second,
         chip_select_third_n, third_select_fitted} = 5'h05;
        host_d = '0;
    end
    // lane selects go with qualifier low
    task automatic drive(input logic [ADDR_W-1:0] a, input logic [4:0] st,
        input logic [3:0] bws, input logic [4:0] sel, input logic [DATA_W-1:0] d);
        addr <= a;
        {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n,
         all_lanes_write_n, lane_write_qualify_n} <= st;
        lane_write_select_n <= bws;
        {output_enable_n, chip_select_first_n, chip_select_second,
         chip_select_third_n, third_select_fitted} <= sel;
        // released lines show the inverse of the last level
        host_d <= (st[1:0] != 2'h3) ? d : ~host_d;
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

// *** verif/test_pipelined_sync_sram_port.sv ***
// self-checking bench for the sync sram port
`timescale 1ns/100ps
`default_nettype none
module test_pipelined_sync_sram_port;
    import sram_port_pkg::*;
    // {proc, ctrl, advance, global, qualify} and {oe, first, second, third, fit}
    localparam logic [4:0] IDL = 5'h1f, PRC = 5'h0f, CTL = 5'h17, STP = 5'h1b;
    localparam logic [4:0] BTH = 5'h07, ALLW = 5'h1d, QW = 5'h1e;
    localparam logic [4:0] ON = 5'h05, OFF = 5'h15;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] addr;
    logic processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n;
    logic lane_write_qualify_n, all_lanes_write_n, chip_select_first_n;
    logic chip_select_second, chip_select_third_n, third_select_fitted;
    logic output_enable_n, data_oe;
    logic [LANES-1:0] lane_write_select_n;
    logic [DATA_W-1:0] data_in, data_out, mem [16];
    int err_total = 0;
    int num_checks = 0;
    sync_sram_port #(.DEPTH(16)) dut (.*);
    sram_host_model host (.*);
    always #25 clk = ~clk;
    task automatic final_report();
        if (err_total == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // look between edges, then hand back on a rising edge
    task automatic cmp_data(input logic [DATA_W-1:0] exp);
        @(negedge clk);
        num_checks++;
        if (data_out !== exp) begin
            err_total++;
            $display("Error %0t: data %h not %h", $time, data_out, exp);
        end
        @(posedge clk);
    endtask
    task automatic cmp_oe(input logic exp);
        @(negedge clk);
        num_checks++;
        if (data_oe !== exp) begin
            err_total++;
            $display("Error %0t: drive %b not %b", $time, data_oe, exp);
        end
        @(posedge clk);
    endtask
    task automatic idle(input int n, input logic [4:0] sel);
        repeat (n) host.drive('0, IDL, 4'hf, sel, '0);
    endtask
    // load with controller strobe, then one write cycle; shadow follows
    task automatic put(input logic [ADDR_W-1:0] a, input logic [4:0] st,
                       input logic [3:0] bws, input logic [DATA_W-1:0] d);
        idle(4, OFF);
        host.drive(a, CTL, 4'hf, OFF, '0);
        host.drive(a, st, bws, OFF, d);
        for (int i = 0; i < LANES; i++) begin
            if (!st[1] || (!st[0] && !bws[i])) begin
                mem[a[3:0]][i*LANE_W +: LANE_W] = d[i*LANE_W +: LANE_W];
            end
        end
    endtask
    // load, step k times, settle, then judge data and drive
    task automatic get(input logic [ADDR_W-1:0] a, input logic [4:0] st,
                       input int k, input logic [4:0] sel, input logic oe);
        logic [1:0] lo;
        lo = a[1:0] + 2'(k);
        host.drive(a, st, 4'hf, sel, '0);
        repeat (k) host.drive('0, STP, 4'hf, sel, '0);
        idle(7, sel);
        cmp_data(mem[{a[3:2], lo}]);
        cmp_oe(oe);
    endtask
    task automatic t_fill();
        for (int i = 0; i < 16; i++) begin
            put(ADDR_W'(i) | 19'h7fff0, ALLW, 4'h5, {4{9'(i * 37)}});
        end
        for (int i = 0; i < 16; i++) begin
            get(ADDR_W'(i), PRC, 0, ON, 1'b1);
        end
    endtask
    task automatic t_lanes();
        put(19'h40005, QW, 4'h6, 36'h123456789);
        put(19'h40005, IDL, 4'h0, 36'hfedcba987);
        get(19'h40005, CTL, 0, ON, 1'b1);
        for (int k = 0; k < 5; k++) begin
            get(19'h00006, BTH, k, ON, 1'b1);
        end
    endtask
    task automatic t_desel();
        logic [4:0] dsel [3] = '{5'h0d, 5'h01, 5'h07};
        get(19'h9, PRC, 0, ON, 1'b1);
        // processor strobe with first select high: burst carries on
        host.drive(19'h3, PRC, 4'hf, 5'h0d, '0);
        host.drive('0, STP, 4'hf, ON, '0);
        idle(7, ON);
        cmp_data(mem[10]);
        foreach (dsel[j]) begin
            repeat (8) host.drive('0, CTL, 4'hf, dsel[j], '0);
            cmp_oe(1'b0);
            // read out of deselect: first output cycle stays off
            host.drive(19'h2, PRC, 4'hf, ON, '0);
            idle(3, ON);
            cmp_oe(1'b0);
            idle(3, ON);
            cmp_oe(1'b1);
            cmp_data(mem[2]);
        end
        get(19'h3, CTL, 0, 5'h06, 1'b1);
        get(19'h4, PRC, 0, OFF, 1'b0);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_fill();
        t_lanes();
        t_desel();
        final_report();
    end
    initial begin
        #(50 * 4000);
        err_total++;
        final_report();
    end
endmodule
`default_nettype wire
